// ---- hw/mnemonic_folder.sv ----
`timescale 1ns/100ps
// folds one mnemonic, character by character, into its short-form code
module mnemonic_folder (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic clear, // start a new mnemonic
  input wire logic push, // take ch_in (already upper case)
  input wire logic [7:0] ch_in, // mnemonic character
  output logic [31:0] code, // short form, left aligned, zero padded
  output logic empty // no character taken yet
);
  import rcp_pkg::*;

  typedef struct packed {
    logic [3:0][7:0] ch;
    logic [3:0] len;
  } fold_s;

  fold_s r, next_r;

  // ************************************************************
  // accumulate first four characters and a saturating length
  // ************************************************************
  // nothing past the fourth character can reach the short form
  always_comb begin
    next_r = clear ? '0 : r;
    if (push) begin
      if (next_r.len < 4'(FOLD_CHARS)) begin
        next_r.ch[3 - next_r.len[1:0]] = ch_in;
      end
      if (next_r.len != FOLD_LEN_MAX) begin
        next_r.len = next_r.len + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // long and short spellings land on the same code
  always_comb begin
    code = r.ch;
    if (r.len > 4'(FOLD_CHARS) && is_vowel(r.ch[0])) begin
      code = {r.ch[3], r.ch[2], r.ch[1], 8'h00};
    end
  end

  assign empty = (r.len == 4'h0);

endmodule : mnemonic_folder

// ---- hw/number_classifier.sv ----
`timescale 1ns/100ps
// classifies one parameter as integer, fixed point, float or text
module number_classifier (
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic clear, // start a new parameter
  input wire logic push, // take ch_in (already upper case)
  input wire logic [7:0] ch_in, // parameter character
  output rcp_pkg::ptype_e ptype // class of the characters so far
);
  import rcp_pkg::*;

  typedef enum logic [3:0] {
    N_START = 4'b0000,
    N_SIGN = 4'b0001,
    N_INT = 4'b0010,
    N_DOT = 4'b0011,
    N_FRAC = 4'b0100,
    N_EXP = 4'b0101,
    N_ESIGN = 4'b0110,
    N_EDIG = 4'b0111,
    N_UNIT = 4'b1000,
    N_TEXT = 4'b1001
  } num_e;

  typedef struct packed {
    num_e st;
    ptype_e unit_of; // numeric class that preceded a unit suffix
  } cls_s;

  cls_s r, next_r;
  num_e cur;

  // ************************************************************
  // per-character recogniser
  // ************************************************************
  // a letter after a complete number is a unit; 'E' after integer or
  // fraction digits is taken as an exponent first, the price of one-character lookahead
  always_comb begin
    next_r = r;
    cur = clear ? N_START : r.st;
    next_r.st = cur;
    if (push) begin
      case (cur)
        N_START: next_r.st = is_digit(ch_in) ? N_INT :
          (ch_in == CH_PLUS || ch_in == CH_MINUS) ? N_SIGN :
          (ch_in == CH_DOT) ? N_DOT : N_TEXT;
        N_SIGN: next_r.st = is_digit(ch_in) ? N_INT :
          (ch_in == CH_DOT) ? N_DOT : N_TEXT;
        N_INT: next_r.st = is_digit(ch_in) ? N_INT :
          (ch_in == CH_DOT) ? N_FRAC : (ch_in == CH_E) ? N_EXP :
          is_alnum(ch_in) ? N_UNIT : N_TEXT;
        N_DOT: next_r.st = is_digit(ch_in) ? N_FRAC : N_TEXT;
        N_FRAC: next_r.st = is_digit(ch_in) ? N_FRAC :
          (ch_in == CH_E) ? N_EXP :
          is_alnum(ch_in) ? N_UNIT : N_TEXT;
        N_EXP: next_r.st = is_digit(ch_in) ? N_EDIG :
          (ch_in == CH_PLUS || ch_in == CH_MINUS) ? N_ESIGN : N_TEXT;
        N_ESIGN: next_r.st = is_digit(ch_in) ? N_EDIG : N_TEXT;
        N_EDIG: next_r.st = is_digit(ch_in) ? N_EDIG :
          is_alnum(ch_in) ? N_UNIT : N_TEXT;
        N_UNIT: next_r.st = is_alnum(ch_in) || ch_in == 8'h2f ?
          N_UNIT : N_TEXT;
        default: next_r.st = N_TEXT;
      endcase
      if (next_r.st == N_UNIT && cur != N_UNIT) begin
        next_r.unit_of = (cur == N_INT) ? P_NR1 :
          (cur == N_FRAC) ? P_NR2 : P_NR3;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: N_START, unit_of: P_NONE};
    end else begin
      r <= next_r;
    end
  end

  // three numeric shapes are told apart
  always_comb begin
    case (r.st)
      N_START: ptype = P_NONE;
      N_INT: ptype = P_NR1;
      N_FRAC: ptype = P_NR2;
      N_EDIG: ptype = P_NR3;
      N_UNIT: ptype = r.unit_of;
      default: ptype = P_TEXT;
    endcase
  end

endmodule : number_classifier

// ---- hw/rcp_pkg.sv ----
package rcp_pkg;

  // ************************************************************
  // line buffer and path geometry
  // ************************************************************
  localparam int BUF_DEPTH = 256;
  localparam logic [7:0] BUF_LAST = 8'hff; // first index never stored; reaching it sets overflow
  localparam logic [1:0] MAX_LEVELS = 2'h3;
  localparam int FOLD_CHARS = 4;
  localparam logic [3:0] FOLD_LEN_MAX = 4'hf;

  // ************************************************************
  // character codes
  // ************************************************************
  localparam logic [7:0] CH_NL = 8'h0a;
  localparam logic [7:0] CH_TAB = 8'h09;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QMARK = 8'h3f;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // ************************************************************
  // optional header nodes (short-form codes, left aligned)
  // ************************************************************
  localparam logic [31:0] OPT_STATE = 32'h53544154; // state node
  localparam logic [31:0] OPT_RATE = 32'h52415445; // rate node
  localparam logic [31:0] OPT_VOLT = 32'h564f4c54; // voltage node

  typedef enum logic [2:0] {
    P_NONE = 3'b000,
    P_NR1 = 3'b001,
    P_NR2 = 3'b010,
    P_NR3 = 3'b011,
    P_TEXT = 3'b100,
    P_STRING = 3'b101
  } ptype_e;
  function automatic logic [7:0] upcase(input logic [7:0] c);
    upcase = (c >= 8'h61 && c <= 8'h7a) ? (c & ~CASE_BIT) : c;
  endfunction : upcase

  function automatic logic is_alnum(input logic [7:0] c);
    is_alnum = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h5a);
  endfunction : is_alnum

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= 8'h30 && c <= 8'h39);
  endfunction : is_digit

  function automatic logic is_space(input logic [7:0] c);
    is_space = (c == CH_SP) || (c == CH_TAB) || (c == CH_CR);
  endfunction : is_space

  function automatic logic is_vowel(input logic [7:0] c);
    is_vowel = (c == 8'h41) || (c == 8'h45) || (c == 8'h49) ||
               (c == 8'h4f) || (c == 8'h55);
  endfunction : is_vowel

  function automatic logic is_optional(input logic [31:0] code);
    is_optional = (code == OPT_STATE) || (code == OPT_RATE) ||
                  (code == OPT_VOLT);
  endfunction : is_optional
endpackage : rcp_pkg

// ---- hw/remote_command_parser.sv ----
`timescale 1ns/100ps
// Functional notes
// - letters match regardless of case in headers, parameters and units.
// - no blank may stand before or after a level colon.
// - first blank ends the header; what follows is the parameter field.
// - a header with no parameters is still a complete command.
// - headers nest at most three levels, the selected subsystem included.
// - long and short spelling of a mnemonic name the same node.
// - a header ending in a question mark is a query.
// - after a plain semicolon the next header stays at the same level.
// - semicolon then colon restarts the path at the root.
// - common commands may sit anywhere in a line, path untouched.
// - over four characters: keep three if fourth is vowel, else four.
// - phrase mnemonics are initials plus last word, then shortened; the folder only shortens the characters it is given.
// - a leading asterisk marks a common command, only some supported.
// - commas separate successive parameters.
// - double-quoted text is one string parameter.
// - numbers are integer, fixed point, or floating with exponent.
// - new-line ends each input line and each output reply.
// - end-or-identify with the last byte also ends a line.
// - each setting answers 1 on success, 0 on failure, then goes on.
// - a trailing optional header node resolves the same present or absent.
module remote_command_parser (
  input wire logic clk, // system clock, 20 MHz
  input wire logic rstn, // async reset, active low
  input wire logic rx_valid, // host byte present
  input wire logic [7:0] rx_data, // host byte
  input wire logic rx_eoi, // end-or-identify with this byte
  output logic rx_ready, // byte taken when high with rx_valid
  output logic cmd_valid, // parsed command offered
  input wire logic cmd_ready, // executor takes the command
  output logic [31:0] cmd_node0, // subsystem or common code
  output logic [31:0] cmd_node1, // second level code
  output logic [31:0] cmd_node2, // third level code
  output logic [1:0] cmd_depth, // levels after optional drop
  output logic cmd_query, // header ended in a question mark
  output logic cmd_common, // asterisk command
  output logic [3:0] cmd_param_count, // parameters in the field
  output rcp_pkg::ptype_e cmd_param_type, // class of first parameter
  output logic [7:0] cmd_param_first, // buffer index of field start
  output logic [7:0] cmd_param_last, // buffer index of field end
  input wire logic [7:0] buf_rd_addr, // executor reads the line
  output logic [7:0] buf_rd_data, // one cycle after the address
  input wire logic exec_done, // executor finished (pulse)
  input wire logic exec_ok, // with exec_done: setting succeeded
  output logic tx_valid, // reply byte offered
  output logic [7:0] tx_data, // reply byte
  input wire logic tx_ready // host link takes the byte
);
  import rcp_pkg::*;

  typedef enum logic [2:0] {
    S_FILL = 3'b000,
    S_HDR = 3'b001,
    S_PARAM = 3'b010,
    S_EMIT = 3'b011,
    S_WAIT = 3'b100,
    S_RESP = 3'b101,
    S_NL = 3'b110,
    S_SKIP = 3'b111
  } state_e;

  typedef struct packed {
    state_e st;
    logic [7:0] wptr;
    logic [7:0] len;
    logic [7:0] rptr;
    logic ovf;
    logic start; // next character opens a command
    logic root; // path restarts at the top
    logic colon_prev; // last header character was a colon
    logic space_prev; // blank seen right after a mnemonic
    logic common;
    logic query;
    logic in_quote;
    logic str; // current parameter is quoted text
    logic seen; // parameter field has begun
    logic [1:0] d; // levels of the header being built
    logic [1:0] sd; // levels of the last tree command
    logic [1:0] od; // levels offered to the executor
    logic [2:0][31:0] path;
    logic [2:0][31:0] spath; // path kept across semicolons
    logic [3:0] pcnt;
    ptype_e ptype;
    logic [7:0] pfirst;
    logic [7:0] plast;
    logic result;
  } parse_s;

  parse_s r, next_r;
  logic [7:0] line_buf [BUF_DEPTH];
  logic [7:0] c;
  logic at_end, fin, err, to_emit, buf_we;
  logic fold_clr, fold_push, cls_clr, cls_push;
  logic [31:0] fold_code;
  logic fold_empty;
  ptype_e cls_type;
  ptype_e cur_type;

  // ************************************************************
  // helpers
  // ************************************************************
  mnemonic_folder u_fold (
    .clk(clk),
    .rstn(rstn),
    .clear(fold_clr),
    .push(fold_push),
    .ch_in(c),
    .code(fold_code),
    .empty(fold_empty)
  );

  number_classifier u_cls (
    .clk(clk),
    .rstn(rstn),
    .clear(cls_clr),
    .push(cls_push),
    .ch_in(c),
    .ptype(cls_type)
  );

  // all comparisons see upper case only
  assign c = upcase(line_buf[r.rptr]);
  assign at_end = (r.rptr == r.len);
  assign cur_type = r.str ? P_STRING : cls_type;

  // ************************************************************
  // parser state machine
  // ************************************************************
  always_comb begin
    next_r = r;
    fin = 1'b0;
    err = 1'b0;
    to_emit = 1'b0;
    buf_we = 1'b0;
    fold_clr = 1'b0;
    fold_push = 1'b0;
    cls_clr = 1'b0;
    cls_push = 1'b0;
    case (r.st)
      S_FILL: begin
        // hold the whole line before parsing any of it
        if (rx_valid) begin
          if (rx_data != CH_NL) begin
            if (r.wptr == BUF_LAST) begin
              next_r.ovf = 1'b1;
            end else begin
              buf_we = 1'b1;
              next_r.wptr = r.wptr + 8'h01;
            end
          end
          if (rx_data == CH_NL || rx_eoi) begin
            next_r.len = next_r.wptr;
            next_r.wptr = 8'h00;
            next_r.rptr = next_r.ovf ? next_r.len : 8'h00;
            next_r.ovf = 1'b0;
            next_r.start = 1'b1;
            next_r.root = 1'b1;
            next_r.colon_prev = 1'b0;
            next_r.st = next_r.ovf ? S_SKIP : S_HDR;
            if (r.ovf || (rx_data != CH_NL && r.wptr == BUF_LAST)) begin
              next_r.st = S_SKIP;
            end
          end
        end
      end
      S_HDR: begin
        if (r.start) begin
          fold_clr = 1'b1;
          if (at_end) begin
            next_r.st = S_FILL;
          end else if (c == CH_COLON) begin
            next_r.root = 1'b1;
            next_r.colon_prev = 1'b1;
            next_r.rptr = r.rptr + 8'h01;
          end else if (is_space(c)) begin
            err = r.colon_prev;
            next_r.rptr = r.rptr + 8'h01;
          end else begin
            // a plain semicolon keeps all but the last level
            next_r.start = 1'b0;
            next_r.common = (c == CH_STAR);
            next_r.d = (r.root || r.sd == 2'h0) ? 2'h0 : r.sd - 2'h1;
            next_r.path = r.spath;
            next_r.query = 1'b0;
            next_r.colon_prev = 1'b0;
            next_r.space_prev = 1'b0;
            next_r.pcnt = 4'h0;
            next_r.ptype = P_NONE;
            next_r.seen = 1'b0;
            next_r.in_quote = 1'b0;
            next_r.str = 1'b0;
            next_r.plast = r.rptr;
            cls_clr = 1'b1;
            if (c == CH_STAR) begin
              next_r.rptr = r.rptr + 8'h01;
            end
          end
        end else if (at_end || c == CH_SEMI) begin
          fin = !r.query; // header alone is a command
          to_emit = 1'b1;
        end else begin
          next_r.rptr = r.rptr + 8'h01;
          next_r.pfirst = r.rptr + 8'h01; // parameters start past here
          if (r.query) begin
            err = !is_space(c);
            next_r.st = S_PARAM;
          end else if (is_alnum(c) && !r.space_prev) begin
            fold_push = 1'b1;
            next_r.colon_prev = 1'b0;
          end else if (c == CH_COLON && !r.common && !r.space_prev) begin
            fin = 1'b1;
            next_r.colon_prev = 1'b1;
          end else if (c == CH_QMARK && !r.colon_prev) begin
            fin = 1'b1;
            next_r.query = 1'b1;
          end else if (is_space(c) && !r.colon_prev) begin
            fin = 1'b1; // blank splits header from parameters
            next_r.st = S_PARAM;
          end else begin
            err = 1'b1; // blank after a colon or stray mark
          end
        end
      end
      S_PARAM: begin
        if (at_end || (c == CH_SEMI && !r.in_quote)) begin
          to_emit = 1'b1;
          if (r.seen) begin
            next_r.pcnt = r.pcnt + 4'h1;
            if (r.pcnt == 4'h0) begin
              next_r.ptype = cur_type;
            end
          end
        end else begin
          next_r.rptr = r.rptr + 8'h01;
          if (!r.seen && is_space(c)) begin
            next_r.pfirst = r.rptr + 8'h01;
          end else if (!r.seen && c == CH_COLON) begin
            err = 1'b1;
          end else begin
            next_r.seen = 1'b1;
            next_r.plast = r.rptr;
            if (c == CH_QUOTE) begin
              next_r.in_quote = !r.in_quote;
              next_r.str = 1'b1;
            end else if (c == CH_COMMA && !r.in_quote) begin
              // each comma closes one parameter
              if (r.pcnt == 4'h0) begin
                next_r.ptype = cur_type;
              end
              next_r.pcnt = r.pcnt + 4'h1;
              next_r.str = 1'b0;
              cls_clr = 1'b1;
            end else if (!r.in_quote) begin
              cls_push = 1'b1;
            end
          end
        end
      end
      S_EMIT: begin
        if (cmd_ready) begin
          next_r.st = S_WAIT;
          if (!r.common) begin
            next_r.spath = r.path; // star commands leave it alone
            next_r.sd = r.d;
          end
        end
      end
      S_WAIT: begin
        if (exec_done) begin
          next_r.result = exec_ok;
          // queries answer with data of their own, settings 1 or 0
          next_r.st = r.query ? (at_end ? S_FILL : S_HDR) : S_RESP;
        end
      end
      S_RESP: begin
        if (tx_ready) begin
          next_r.st = S_NL;
        end
      end
      S_NL: begin
        if (tx_ready) begin
          next_r.st = at_end ? S_FILL : S_HDR; // next command goes on
        end
      end
      S_SKIP: begin
        // drop the rest of a failed command up to its semicolon
        next_r.result = 1'b0;
        if (at_end || (c == CH_SEMI && !r.in_quote)) begin
          next_r.st = S_RESP; // failure answered with 0
          next_r.start = 1'b1;
          next_r.root = 1'b0;
          next_r.rptr = at_end ? r.rptr : r.rptr + 8'h01;
        end else begin
          next_r.rptr = r.rptr + 8'h01;
          next_r.in_quote = r.in_quote ^ (c == CH_QUOTE);
        end
      end
      default: next_r.st = S_FILL;
    endcase

    // close one mnemonic into the path
    if (fin) begin
      fold_clr = 1'b1;
      if (fold_empty) begin
        err = 1'b1;
      end else if (r.common) begin
        next_r.path[0] = fold_code;
        next_r.d = 2'h1;
      end else if (r.d == MAX_LEVELS) begin
        err = 1'b1; // tree is only three deep
      end else begin
        next_r.path[r.d] = fold_code;
        next_r.d = r.d + 2'h1;
      end
      next_r.space_prev = (r.st == S_HDR) && is_space(c);
    end
    if (to_emit && !err) begin
      next_r.st = S_EMIT;
      next_r.start = 1'b1;
      next_r.root = r.common && r.root; // a star keeps a pending restart
      next_r.colon_prev = 1'b0;
      next_r.rptr = at_end ? r.rptr : r.rptr + 8'h01;
      // trailing optional node below the first level of a tree command is resolved as if absent
      next_r.od = next_r.d;
      if (!r.common && next_r.d >= 2'h2 &&
          is_optional(next_r.path[next_r.d - 2'h1])) begin
        next_r.od = next_r.d - 2'h1;
      end
    end
    if (err) begin
      next_r.st = S_SKIP;
      next_r.in_quote = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: S_FILL, ptype: P_NONE, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // line storage and executor read port; no reset needed on data
  always_ff @(posedge clk) begin
    if (buf_we) begin
      line_buf[r.wptr] <= rx_data;
    end
    buf_rd_data <= line_buf[buf_rd_addr];
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rx_ready = (r.st == S_FILL);
  assign cmd_valid = (r.st == S_EMIT);
  assign cmd_node0 = r.path[0];
  assign cmd_node1 = r.path[1];
  assign cmd_node2 = r.path[2];
  assign cmd_depth = r.od;
  assign cmd_query = r.query;
  assign cmd_common = r.common;
  assign cmd_param_count = r.pcnt;
  assign cmd_param_type = r.ptype;
  assign cmd_param_first = r.pfirst;
  assign cmd_param_last = r.plast;
  assign tx_valid = (r.st == S_RESP) || (r.st == S_NL);
  // reply char then new-line
  assign tx_data = (r.st == S_NL) ? CH_NL : (r.result ? CH_ONE : CH_ZERO);

endmodule : remote_command_parser

// ---- testbench/host_model.sv ----
`timescale 1ns/100ps
// host: sends lines, takes reply bytes with random stalls
module host_model (
  input wire logic clk, // clock
  output logic rx_valid, // byte offered
  output logic [7:0] rx_data, // byte
  output logic rx_eoi, // end-or-identify
  input wire logic rx_ready, // byte taken
  input wire logic tx_valid, // reply offered
  input wire logic [7:0] tx_data, // reply byte
  output logic tx_ready // reply taken
);
  logic [7:0] got[$];
  logic stuck = 0;
  initial {rx_valid, rx_eoi, tx_ready, rx_data} = 0;
  // stalls a third of the time so held reply bytes get exercised
  always @(posedge clk) begin
    if (tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= $urandom_range(2) != 0;
  end
  // last byte carries new-line or eoi; each byte held up to ten cycles, stuck flagged if not taken
  task automatic send(input string s, input bit eoi);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1;
      rx_data <= s[i];
      rx_eoi <= eoi && i == s.len() - 1;
      @(posedge clk);
      for (int k = 0; k < 9 && !rx_ready; k++) @(posedge clk);
      stuck |= !rx_ready;
    end
    rx_valid <= 0;
    rx_data <= ~rx_data; // released: no stale byte
    rx_eoi <= 0;
  endtask : send
endmodule : host_model

// ---- testbench/rcp_checker_sva.sv ----
`timescale 1ns/100ps
// watches host, command and reply ports of the parser
module rcp_checker (
  input wire logic clk, // clock
  input wire logic rstn, // reset, low
  input wire logic rx_valid, // byte present
  input wire logic [7:0] rx_data, // byte
  input wire logic rx_eoi, // end-or-identify
  input wire logic rx_ready, // byte taken
  input wire logic cmd_valid, // command offered
  input wire logic cmd_ready, // command taken
  input wire logic [31:0] cmd_node0, // first node
  input wire logic [1:0] cmd_depth, // node count
  input wire logic cmd_query, // query flag
  input wire logic exec_done, // executor done
  input wire logic exec_ok, // setting ok
  input wire logic tx_valid, // reply offered
  input wire logic [7:0] tx_data, // reply byte
  input wire logic tx_ready // reply taken
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_reply_char:
    assert property (exec_done && !cmd_query |=> tx_valid &&
      tx_data == ($past(exec_ok) ? 8'h31 : 8'h30)) else $error("result");
  chk_query_quiet:
    assert property (exec_done && cmd_query |=> !tx_valid [*2])
      else $error("query replied");
  chk_tx_hold:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("reply dropped");
  chk_nl_follow:
    assert property (tx_valid && tx_ready && tx_data != 8'h0a |=>
      tx_valid && tx_data == 8'h0a) else $error("no new-line");
  chk_nl_closes:
    assert property (rx_valid && rx_ready && rx_data == 8'h0a |=>
      !rx_ready [*3]) else $error("line not closed");
  chk_eoi_closes:
    assert property (rx_valid && rx_ready && rx_eoi |=> !rx_ready [*3])
      else $error("eoi not honoured");
  chk_cmd_hold:
    assert property (cmd_valid && !cmd_ready |=> cmd_valid &&
      $stable(cmd_node0) && $stable(cmd_depth)) else $error("offer moved");
  chk_one_busy:
    assert property (tx_valid || cmd_valid |-> !rx_ready && !(tx_valid &&
      cmd_valid)) else $error("overlap");
endmodule : rcp_checker
bind remote_command_parser rcp_checker u_chk (.*);

// ---- testbench/remote_command_parser_bench.sv ----
`timescale 1ns/100ps
module remote_command_parser_bench;
  import rcp_pkg::*;
  typedef struct {logic [31:0] n[3]; int d, q, c, pc, pt, pf, pl;} exp_s;
  logic clk = 0, rstn = 0, rx_valid, rx_eoi, rx_ready, cmd_valid, cmd_ready;
  logic cmd_query, cmd_common, exec_done, exec_ok, tx_valid, tx_ready;
  logic [7:0] rx_data, tx_data, buf_rd_addr, buf_rd_data;
  logic [7:0] cmd_param_first, cmd_param_last;
  logic [31:0] cmd_node0, cmd_node1, cmd_node2;
  logic [1:0] cmd_depth;
  logic [3:0] cmd_param_count;
  ptype_e cmd_param_type;
  int n_fail = 0, tests_run = 0;
  exp_s eq[$];
  string path[$];
  always #25 clk = ~clk;
  remote_command_parser u_dut (.*);
  host_model u_host (.*);
  // ********
  // reference model
  // ********
  function automatic logic [31:0] fold(input string m);
    logic [31:0] c = 0;
    int n = m.len() > 4 ? 4 : m.len();
    if (n == 4 && m.len() > 4 && m[3] inside {"A", "E", "I", "O", "U"}) n = 3;
    for (int i = 0; i < n; i++) c[31-8*i -: 8] = m[i];
    return c;
  endfunction : fold
  task automatic model(input string ln);
    string s, h, p, nd[$];
    int k;
    exp_s e;
    ln = ln.toupper();
    path = {};
    while (ln.len() > 0) begin
      for (k = 0; k < ln.len() && ln[k] != ";"; k++);
      s = ln.substr(0, k - 1);
      ln = ln.substr(k + 1, ln.len() - 1);
      for (k = 0; k < s.len() && s[k] != " "; k++);
      h = s.substr(0, k - 1);
      p = s.substr(k + 1, s.len() - 1);
      e = '{default: 0};
      e.q = h[h.len()-1] == "?";
      if (e.q) h = h.substr(0, h.len() - 2);
      e.c = h[0] == "*";
      if (h[0] == ":") path = {};
      if (h[0] == ":") h = h.substr(1, h.len() - 1);
      if (e.c) nd = {h.substr(1, h.len() - 1)};
      else begin
        if (path.size() > 0) void'(path.pop_back());
        nd = path;
        for (int i = 0, j = 0; i <= h.len(); i++)
          if (i == h.len() || h[i] == ":") begin
            nd.push_back(h.substr(j, i - 1));
            j = i + 1;
          end
        path = nd;
      end
      if (nd.size() > 1 && fold(nd[$]) inside {OPT_STATE, OPT_RATE, OPT_VOLT})
        void'(nd.pop_back());
      e.d = nd.size();
      foreach (nd[i]) e.n[i] = fold(nd[i]);
      e.pc = p.len() > 0;
      e.pf = p[0];
      e.pl = p.len() - 1;
      for (int i = 0; i < p.len(); i++) e.pc += p[i] == ",";
      e.pt = p == "" ? 0 : p[0] == "\"" ? 5 : p[0] >= "A" ? 4 : 1;
      for (int i = 0; i < p.len() && p[i] != "," && e.pt < 4; i++)
        if (p[i] == "E" || p[i] == "." && e.pt < 3) e.pt = p[i] == "E" ? 3 : 2;
      eq.push_back(e);
    end
  endtask : model
  task automatic chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // one line in, every offered command checked, replies gathered
  task automatic run(input string ln, input bit eoi, bad);
    exp_s e;
    string want = bad ? "0\n" : "";
    int n;
    bit ok;
    if (!bad) model(ln);
    u_host.got = {};
    u_host.send(eoi ? ln : {ln, "\n"}, eoi);
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (rx_ready && n > 0) break;
      if (cmd_valid) begin
        e = eq.pop_front();
        for (int i = 0; i < e.d; i++)
          chk("node", e.n[i], i == 0 ? cmd_node0 : i == 1 ? cmd_node1 : cmd_node2);
        chk("depth", e.d, cmd_depth);
        chk("query", e.q, cmd_query);
        chk("common", e.c, cmd_common);
        chk("params", e.pc, cmd_param_count);
        chk("ptype", e.pt, cmd_param_type);
        if (e.pc) chk("span", e.pl, cmd_param_last - cmd_param_first);
        ok = $urandom;
        if (!e.q) want = {want, ok ? "1\n" : "0\n"};
        cmd_ready <= 1;
        buf_rd_addr <= cmd_param_first;
        @(posedge clk);
        {cmd_ready, exec_done, exec_ok} <= {2'b01, ok};
        @(posedge clk);
        exec_done <= 0;
        if (e.pc) chk("param char", e.pf, buf_rd_data);
      end
    end
    if (n == 3000 || u_host.stuck) n_fail++;
    if (n == 3000 || u_host.stuck) report_and_stop();
    chk("left", 0, eq.size());
    chk("reply count", want.len(), u_host.got.size());
    for (int i = 0; i < want.len(); i++)
      chk("reply", want[i], u_host.got[i]);
  endtask : run
  initial begin
    string s = "";
    void'($urandom(32'h9cf282a4));
    {cmd_ready, exec_done, exec_ok, buf_rd_addr} = 0;
    repeat (8) @(posedge clk);
    rstn <= 1;
    run("TRIGGER:DELETE 12", 0, 0);
    run("trig:del 1000v", 0, 0);
    run("DiSp:PAGe MEas;WAVE STD;:SRATE:RATE 12.3E+5", 0, 0);
    run("*RST;COMP:AREA:LIM ON;RANG 0,960;*trg", 0, 0);
    run("SWAVE:CHOOSE;:DISP:GRID?", 0, 0);
    run("VOLT \"ab cd\",12.5", 1, 0);
    run("COMP : AREA ON", 0, 1);
    run("A:B:C:D 1", 0, 1);
    repeat (260) s = {s, "A"};
    run(s, 0, 1);
    repeat (3) run($sformatf("FREQ:TIME %0d.%0dE-%0d", $urandom_range(99),
      $urandom_range(9), $urandom_range(9)), 0, 0);
    report_and_stop();
  end
endmodule : remote_command_parser_bench
